/* pkg/dca_pkg.sv */
`default_nettype none

package dca_pkg;

  // ---------------------------------------------
  // clock and time base
  // ---------------------------------------------
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned OFS_STEP_NS  = 100;
  localparam int unsigned OFS_STEP_CYC = (OFS_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PPS_WIDTH_US = 10;
  localparam int unsigned PPS_WIDTH_CYC = PPS_WIDTH_US * CLK_MHZ;
  localparam int unsigned BAUD_BPS     = 9600;
  localparam int unsigned BAUD_CYC     = CLK_HZ / BAUD_BPS;
  localparam int unsigned SETTLE_CYC   = 16;
  localparam int unsigned ACC_SCALE    = 3;

  // ---------------------------------------------
  // widths
  // ---------------------------------------------
  localparam int unsigned OFS_W  = 24;
  localparam int unsigned OCYC_W = 26;
  localparam int unsigned SEC_W  = 26;
  localparam int unsigned ACC_W  = 28;
  localparam int unsigned TMO_W  = 27;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned BAUD_W = 13;
  localparam int unsigned PPSW_W = 9;
  localparam int unsigned SET_W  = 5;

  // ---------------------------------------------
  // accumulator steps, 2*f*ACC_SCALE
  // ---------------------------------------------
  localparam logic [ACC_W-1:0] INC_9600 = 28'h000_E100;
  localparam logic [ACC_W-1:0] INC_300  = 28'h000_0708;
  localparam logic [ACC_W-1:0] INC_33   = 28'h000_00C8;

  // ---------------------------------------------
  // switch bit positions and reset values
  // ---------------------------------------------
  localparam int unsigned SW_BAUD_POS = 5;
  localparam logic [4:0]  RELAY_RST   = 5'h00;
  localparam logic        CLK_ON_RST  = 1'h0;

  typedef struct packed {
    logic a;
    logic b;
  } dca_diff_t;

  typedef struct packed {
    logic at1;
    logic at2;
    logic at3;
    logic major;
    logic minor;
  } dca_relay_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              baud_rsv;
  } dca_cfg_t;

  typedef enum logic {
    CFG_SETTLE,
    CFG_HOLD
  } dca_cfg_state_t;

endpackage

`default_nettype wire

/* rtl/dca_data_clock_alarm.sv */
`timescale 1ns/10ps
`default_nettype none

module dca_data_clock_alarm
  import dca_pkg::*;
#(
  parameter int unsigned SEC_CYC = CLK_HZ,
  parameter int unsigned BIT_CYC = BAUD_CYC
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              gps_pps_pin,
  input  wire logic              tracking_pin,
  input  wire logic [5:0]        setup_sw_pin,
  input  wire logic [OFS_W-1:0]  pulse_offset_command,
  input  wire logic              low_rate_clock_select_command,
  input  wire logic [TMO_W-1:0]  first_alarm_timeout,
  input  wire logic [TMO_W-1:0]  second_alarm_timeout,
  input  wire logic [TMO_W-1:0]  third_alarm_timeout,
  input  wire logic              rx_dest_valid,
  input  wire logic [ADDR_W-1:0] rx_dest_addr,
  output var  dca_diff_t         data_clk_9600,
  output var  dca_diff_t         data_clk_low,
  output var  dca_diff_t         data_clk_pps,
  output var  dca_relay_t        relay_energise,
  output logic [1:0]             at_od_o,
  output logic [1:0]             at_od_oe,
  output logic [ADDR_W-1:0]      bus_addr,
  output logic                   baud_reserved,
  output logic                   cfg_valid,
  output logic                   baud_tick,
  output logic                   rx_accept,
  output logic                   rx_reject,
  output logic [ADDR_W-1:0]      tx_src_addr,
  output logic                   epoch_pulse
);

  localparam logic [ACC_W-1:0]  ACC_MOD  = ACC_W'(ACC_SCALE * SEC_CYC);
  localparam logic [SEC_W-1:0]  SEC_LAST = SEC_W'(SEC_CYC - 1);
  localparam logic [BAUD_W-1:0] BIT_LAST = BAUD_W'(BIT_CYC - 1);
  localparam logic [PPSW_W-1:0] PPS_LEN  = PPSW_W'(PPS_WIDTH_CYC);
  localparam logic [SET_W-1:0]  SET_LAST = SET_W'(SETTLE_CYC - 1);
  localparam logic [OCYC_W-1:0] OFS_MUL  = OCYC_W'(OFS_STEP_CYC);

  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic       pps_d_r;
  wire        pps_s;
  wire        trk_s;
  wire  [5:0] sw_s;
  wire        gps_rise;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
      pps_d_r    <= 1'h0;
    end else begin
      pin_meta_r <= {gps_pps_pin, tracking_pin, setup_sw_pin};
      pin_sync_r <= pin_meta_r;
      pps_d_r    <= pps_s;
    end
  end

  assign pps_s    = pin_sync_r[7];
  assign trk_s    = pin_sync_r[6];
  assign sw_s     = pin_sync_r[5:0];
  assign gps_rise = pps_s & ~pps_d_r;

  // ---------------------------------------------
  // switch capture after reset
  // ---------------------------------------------
  dca_cfg_state_t   cfg_st_r;
  dca_cfg_t         cfg_r;
  logic [SET_W-1:0] set_cnt_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_st_r  <= CFG_SETTLE;
      cfg_r     <= '0;
      set_cnt_r <= '0;
    end else begin
      unique case (cfg_st_r)
        CFG_SETTLE: begin
          set_cnt_r <= set_cnt_r + 1'b1;
          if (set_cnt_r == SET_LAST) begin
            cfg_r.addr     <= sw_s[ADDR_W-1:0];
            cfg_r.baud_rsv <= sw_s[SW_BAUD_POS];
            cfg_st_r       <= CFG_HOLD;
          end
        end
        CFG_HOLD: begin
          cfg_st_r <= CFG_HOLD;
        end
      endcase
    end
  end

  assign cfg_valid     = (cfg_st_r == CFG_HOLD);
  assign bus_addr      = cfg_r.addr;
  assign baud_reserved = cfg_r.baud_rsv;

  // ---------------------------------------------
  // command port bit timing
  // ---------------------------------------------
  logic [BAUD_W-1:0] bit_cnt_r;
  logic              baud_tick_r;
  wire               bit_end;

  assign bit_end = (bit_cnt_r == BIT_LAST);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_r   <= '0;
      baud_tick_r <= 1'h0;
    end else begin
      baud_tick_r <= cfg_valid && bit_end;
      if (!cfg_valid || bit_end) begin
        bit_cnt_r <= '0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
    end
  end

  assign baud_tick = baud_tick_r;

  // ---------------------------------------------
  // address filter
  // ---------------------------------------------
  logic rx_acc_r;
  logic rx_rej_r;
  wire  dest_hit;

  assign dest_hit = (rx_dest_addr == cfg_r.addr);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_acc_r <= 1'h0;
      rx_rej_r <= 1'h0;
    end else begin
      rx_acc_r <= rx_dest_valid && cfg_valid && dest_hit;
      rx_rej_r <= rx_dest_valid && !(cfg_valid && dest_hit);
    end
  end

  assign rx_accept   = rx_acc_r;
  assign rx_reject   = rx_rej_r;
  assign tx_src_addr = cfg_r.addr;

  // ---------------------------------------------
  // epoch: offset gps pulse or free-run second
  // ---------------------------------------------
  logic [OCYC_W-1:0] dly_r;
  logic              dly_busy_r;
  logic [SEC_W-1:0]  sec_r;
  wire  [OCYC_W-1:0] ofs_cyc;
  wire               ofs_fire;
  wire               epoch;

  assign ofs_cyc  = OCYC_W'(pulse_offset_command) * OFS_MUL;
  assign ofs_fire = (gps_rise && ofs_cyc == '0)
                 || (dly_busy_r && dly_r == OCYC_W'(1));
  assign epoch    = ofs_fire || (sec_r == SEC_LAST);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dly_r      <= '0;
      dly_busy_r <= 1'h0;
    end else if (gps_rise && ofs_cyc != '0) begin
      dly_r      <= ofs_cyc;
      dly_busy_r <= 1'h1;
    end else if (dly_busy_r) begin
      dly_r      <= dly_r - 1'b1;
      dly_busy_r <= (dly_r != OCYC_W'(1));
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sec_r <= '0;
    end else if (epoch) begin
      sec_r <= '0;
    end else begin
      sec_r <= sec_r + 1'b1;
    end
  end

  assign epoch_pulse = epoch;

  // ---------------------------------------------
  // 9600 Hz and low-rate clock generators
  // ---------------------------------------------
  wire  [ACC_W-1:0] inc_w [2];
  logic [ACC_W-1:0] acc_r [2];
  logic [1:0]       clk_on_r;

  assign inc_w[0] = INC_9600;
  assign inc_w[1] = low_rate_clock_select_command ? INC_33 : INC_300;

  for (genvar g = 0; g < 2; g++) begin : g_dclk
    wire [ACC_W-1:0] sum;
    assign sum = acc_r[g] + inc_w[g];
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        acc_r[g]    <= '0;
        clk_on_r[g] <= CLK_ON_RST;
      end else if (epoch) begin
        acc_r[g]    <= '0;
        clk_on_r[g] <= 1'h1;
      end else if (sum >= ACC_MOD) begin
        acc_r[g]    <= sum - ACC_MOD;
        clk_on_r[g] <= ~clk_on_r[g];
      end else begin
        acc_r[g]    <= sum;
      end
    end
  end

  // ---------------------------------------------
  // one pulse per second
  // ---------------------------------------------
  logic [PPSW_W-1:0] pps_cnt_r;
  logic              pps_on_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pps_cnt_r <= '0;
      pps_on_r  <= CLK_ON_RST;
    end else if (epoch) begin
      pps_cnt_r <= PPS_LEN;
      pps_on_r  <= 1'h1;
    end else if (pps_cnt_r != '0) begin
      pps_cnt_r <= pps_cnt_r - 1'b1;
      pps_on_r  <= (pps_cnt_r != PPSW_W'(1));
    end
  end

  // active phase is space, A high
  assign data_clk_9600 = '{a: clk_on_r[0], b: ~clk_on_r[0]};
  assign data_clk_low  = '{a: clk_on_r[1], b: ~clk_on_r[1]};
  assign data_clk_pps  = '{a: pps_on_r, b: ~pps_on_r};

  // ---------------------------------------------
  // alarm timeouts
  // ---------------------------------------------
  wire  [TMO_W-1:0] preset_w [3];
  logic [TMO_W-1:0] tmo_r    [3];
  logic [2:0]       alm_r;

  assign preset_w[0] = first_alarm_timeout;
  assign preset_w[1] = second_alarm_timeout;
  assign preset_w[2] = third_alarm_timeout;

  for (genvar t = 0; t < 3; t++) begin : g_tmo
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        tmo_r[t] <= '0;
        alm_r[t] <= 1'h0;
      end else if (!cfg_valid || trk_s) begin
        tmo_r[t] <= preset_w[t];
        alm_r[t] <= 1'h0;
      end else if (tmo_r[t] == '0) begin
        alm_r[t] <= 1'h1;
      end else if (epoch) begin
        tmo_r[t] <= tmo_r[t] - 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // relays, fail-safe energised
  // ---------------------------------------------
  dca_relay_t relay_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      relay_r <= RELAY_RST;
    end else begin
      relay_r.at1   <= ~alm_r[0];
      relay_r.at2   <= ~alm_r[1];
      relay_r.at3   <= ~alm_r[2];
      relay_r.major <= ~(alm_r[1] | alm_r[2]);
      relay_r.minor <= ~alm_r[0];
    end
  end

  assign relay_energise = relay_r;
  assign at_od_o        = 2'h0;
  assign at_od_oe       = {relay_r.at2, relay_r.at1};

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  property p_epoch_sec;
    @(posedge clock) disable iff (rst)
      epoch |=> (sec_r == '0);
  endproperty
  a_epoch_sec: assert property (p_epoch_sec)
    else $error("second counter not restarted at epoch");

  property p_lead_edge;
    @(posedge clock) disable iff (rst)
      epoch |=> (data_clk_9600.a && data_clk_low.a && data_clk_pps.a);
  endproperty
  a_lead_edge: assert property (p_lead_edge)
    else $error("clocks not at leading level after epoch");

  property p_offset_one;
    @(posedge clock) disable iff (rst)
      (gps_rise && pulse_offset_command == OFS_W'(1) && !dly_busy_r
       && sec_r < SEC_W'(SEC_CYC - 8)) |-> !epoch ##1 (!epoch)[*3] ##1 epoch;
  endproperty
  a_offset_one: assert property (p_offset_one)
    else $error("offset of one step not four cycles");

  property p_diff;
    @(posedge clock) disable iff (rst)
      (data_clk_9600.a != data_clk_9600.b) && (data_clk_pps.a != data_clk_pps.b);
  endproperty
  a_diff: assert property (p_diff)
    else $error("differential pair not complementary");

  property p_od_alarm;
    @(posedge clock) disable iff (rst)
      $rose(alm_r[0]) |=> !at_od_oe[0];
  endproperty
  a_od_alarm: assert property (p_od_alarm)
    else $error("timeout pin still grounded during alarm");

  property p_addr_hold;
    @(posedge clock) disable iff (rst)
      cfg_valid |=> (cfg_valid && $stable(bus_addr));
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("captured address changed");

  property p_major;
    @(posedge clock) disable iff (rst)
      (alm_r[1] || alm_r[2]) |=> !relay_energise.major;
  endproperty
  a_major: assert property (p_major)
    else $error("major relay energised during major alarm");

  property p_recover;
    @(posedge clock) disable iff (rst)
      (trk_s && cfg_valid) |=> (alm_r == 3'h0) ##1 relay_energise.at1;
  endproperty
  a_recover: assert property (p_recover)
    else $error("relay not restored after tracking returned");

  property p_expire;
    @(posedge clock) disable iff (rst)
      (cfg_valid && !trk_s && tmo_r[2] == '0) |=> alm_r[2];
  endproperty
  a_expire: assert property (p_expire)
    else $error("timeout reached zero without alarm");

  property p_filter;
    @(posedge clock) disable iff (rst)
      (rx_dest_valid && rx_dest_addr != bus_addr) |=> (!rx_accept && rx_reject);
  endproperty
  a_filter: assert property (p_filter)
    else $error("foreign destination accepted");

  property p_baud;
    @(posedge clock) disable iff (rst)
      baud_tick |=> (!baud_tick)[*8];
  endproperty
  a_baud: assert property (p_baud)
    else $error("bit ticks too close together");

endmodule

`default_nettype wire

/* dv/dca_far_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------
// far side: gps receiver and bus host
// ---------------------------------------------
module dca_far_model
  import dca_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              fire,
  input  wire logic              lock,
  input  wire logic              send,
  input  wire logic [ADDR_W-1:0] dest,
  output logic                   gps_pps_pin,
  output logic                   tracking_pin,
  output logic                   rx_dest_valid,
  output logic [ADDR_W-1:0]      rx_dest_addr
);
  int width_r = 0;

  initial begin
    gps_pps_pin = 1'h0;
    tracking_pin = 1'h0;
    rx_dest_valid = 1'h0;
    rx_dest_addr = '0;
  end

  always @(posedge clock) begin
    width_r <= fire ? 100 : (width_r > 0 ? width_r - 1 : 0);
    gps_pps_pin <= #3 (fire || width_r > 1);
    tracking_pin <= #7 lock;
  end

  always @(posedge clock) begin
    rx_dest_valid <= send;
    rx_dest_addr <= send ? dest : ~rx_dest_addr;
  end
endmodule

`default_nettype wire

/* dv/dca_data_clock_alarm_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module dca_data_clock_alarm_tb_top
  import dca_pkg::*;
;
  localparam int SEC = 60000;
  localparam int BIT = 20;
  localparam int WIN = 1990;

  typedef struct packed {
    logic [5:0] sw;
    logic [4:0] addr;
    logic       rsv;
  } dca_row_t;

  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic              clock = 1'h0;
  logic              rst;
  logic [5:0]        sw;
  logic [OFS_W-1:0]  ofs;
  logic              sel;
  logic [TMO_W-1:0]  t1;
  logic [TMO_W-1:0]  t2;
  logic [TMO_W-1:0]  t3;
  logic              fire;
  logic              lock;
  logic              send;
  logic [ADDR_W-1:0] dest;
  logic              gps;
  logic              trk;
  logic              rxv;
  logic [ADDR_W-1:0] rxa;
  dca_diff_t         clk96;
  dca_diff_t         clklo;
  dca_diff_t         clkpps;
  dca_relay_t        relay;
  logic [1:0]        od_o;
  logic [1:0]        od_oe;
  logic [ADDR_W-1:0] addr;
  logic              rsv;
  logic              cfgv;
  logic              btick;
  logic              acc;
  logic              rej;
  logic [ADDR_W-1:0] src;
  logic              epoch;
  logic              a9;
  logic              al;
  int                bad_count = 0;
  int                samples_checked = 0;
  int                n0;
  int                n1;
  int                r9;
  int                rl;
  dca_row_t          rows [5] = '{'{6'h00, 5'h00, 1'h0}, '{6'h01, 5'h01, 1'h0},
                                  '{6'h30, 5'h10, 1'h1}, '{6'h1F, 5'h1F, 1'h0},
                                  '{6'h2A, 5'h0A, 1'h1}};

  always #12.5 clock = ~clock;

  dca_data_clock_alarm #(.SEC_CYC(SEC), .BIT_CYC(BIT)) DUT (
    .clock(clock), .rst(rst), .gps_pps_pin(gps), .tracking_pin(trk),
    .setup_sw_pin(sw), .pulse_offset_command(ofs),
    .low_rate_clock_select_command(sel), .first_alarm_timeout(t1),
    .second_alarm_timeout(t2), .third_alarm_timeout(t3),
    .rx_dest_valid(rxv), .rx_dest_addr(rxa), .data_clk_9600(clk96),
    .data_clk_low(clklo), .data_clk_pps(clkpps), .relay_energise(relay),
    .at_od_o(od_o), .at_od_oe(od_oe), .bus_addr(addr), .baud_reserved(rsv),
    .cfg_valid(cfgv), .baud_tick(btick), .rx_accept(acc), .rx_reject(rej),
    .tx_src_addr(src), .epoch_pulse(epoch)
  );

  dca_far_model far (
    .clock(clock), .fire(fire), .lock(lock), .send(send), .dest(dest),
    .gps_pps_pin(gps), .tracking_pin(trk), .rx_dest_valid(rxv),
    .rx_dest_addr(rxa)
  );

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %0h want %0h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task wait_cfg;
    n0 = 0;
    while (cfgv !== 1'h1 && n0 < 100) begin
      @(negedge clock);
      n0++;
    end
    chk(cfgv, 1'h1);
  endtask

  task reset_dut;
    @(posedge clock) rst <= 1'h1;
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    wait_cfg();
  endtask

  task frame(input logic [4:0] d, input logic ok);
    @(posedge clock) send <= 1'h1;
    dest <= d;
    @(posedge clock) send <= 1'h0;
    tick(1);
    chk(rxv, 1'h1);
    tick(1);
    chk({acc, rej}, {ok, ~ok});
  endtask

  task gps_edge(output int n);
    tick(150);
    n = 0;
    @(posedge clock) fire <= 1'h1;
    @(posedge clock) fire <= 1'h0;
    do begin
      @(negedge clock);
      n++;
    end while (epoch !== 1'h1 && n < 3000);
    chk(epoch, 1'h1);
  endtask

  task results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    rst = 1'h1;
    sw = 6'h00;
    ofs = '0;
    sel = 1'h0;
    t1 = '0;
    t2 = '0;
    t3 = '0;
    fire = 1'h0;
    lock = 1'h1;
    send = 1'h0;
    dest = '0;
    foreach (rows[i]) begin
      @(posedge clock) sw <= rows[i].sw;
      reset_dut();
      chk(addr, rows[i].addr);
      chk(rsv, rows[i].rsv);
      chk(src, rows[i].addr);
      frame(rows[i].addr, 1'h1);
      frame(rows[i].addr ^ 5'h01, 1'h0);
      @(posedge clock) sw <= ~rows[i].sw;
      n1 = 0;
      repeat (10 * BIT) begin
        @(negedge clock);
        if (btick === 1'h1) n1++;
      end
      chk(n1, 10);
      chk(addr, rows[i].addr);
      $display("switch row %0d done", i);
    end
    @(posedge clock) rst <= 1'h1;
    tick(2);
    chk({clk96, clklo, clkpps}, 6'h15);
    chk(relay, 5'h00);
    chk(od_oe, 2'h0);
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    frame(5'h15, 1'h0);
    wait_cfg();
    frame(5'h15, 1'h1);
    $display("reset test done");
    for (int s = 0; s < 2; s++) begin
      @(posedge clock) sel <= (s == 1);
      gps_edge(n0);
      a9 = 1'h0;
      al = 1'h0;
      r9 = 0;
      rl = 0;
      for (int i = 0; i < WIN; i++) begin
        @(negedge clock);
        if (clk96.a === 1'h1 && a9 === 1'h0) r9++;
        if (clklo.a === 1'h1 && al === 1'h0) rl++;
        a9 = clk96.a;
        al = clklo.a;
        if (i == 0) chk({clk96, clklo, clkpps}, 6'h2A);
        if (i == PPS_WIDTH_CYC - 1) chk(clkpps, 2'h2);
        if (i == PPS_WIDTH_CYC) chk(clkpps, 2'h1);
      end
      chk(r9, (WIN * 9600 + SEC - 1) / SEC);
      chk(rl, s == 1 ? (WIN * 100 + 3 * SEC - 1) / (3 * SEC) : (WIN * 300 + SEC - 1) / SEC);
      $display("clock rate test %0d done", s);
    end
    gps_edge(n0);
    @(posedge clock) ofs <= 24'h00_0005;
    gps_edge(n1);
    chk(n1 - n0, 5 * OFS_STEP_CYC);
    @(posedge clock) ofs <= 24'h00_0001;
    gps_edge(n1);
    chk(n1 - n0, OFS_STEP_CYC);
    @(posedge clock) ofs <= '0;
    $display("offset test done");
    @(posedge clock) t2 <= 27'h000_0001;
    t3 <= 27'h000_0003;
    tick(10);
    chk(relay, 5'h1F);
    @(posedge clock) lock <= 1'h0;
    tick(10);
    chk(relay, 5'h0E);
    chk(od_oe, 2'h2);
    gps_edge(n0);
    tick(6);
    chk(relay, 5'h04);
    chk(od_oe, 2'h0);
    gps_edge(n0);
    gps_edge(n0);
    tick(6);
    chk(relay, 5'h00);
    @(posedge clock) lock <= 1'h1;
    tick(10);
    chk(relay, 5'h1F);
    chk({od_o, od_oe}, 4'h3);
    $display("alarm test done");
    results();
  end

  initial begin
    #(25 * 50000);
    bad_count++;
    $display("watchdog expired");
    results();
  end
endmodule

`default_nettype wire
